// *** logic/gpio_port_params.svh ***
// Function
// - six-bit bidirectional port with one direction bit per pin
// - direction bit one makes the pin an input, driver released
// - direction bit zero drives the pin from the output latch
// - pin three is input only; its direction bit always reads one
// - data read returns pin levels; data write updates the output latch
// - writes store the written bits into the latch; the sampled pin levels cancel out
// - pin three reads zero while the reset-pin function is enabled
// - direction still governs analog pins; analog pins read zero
// - an enabled sharing peripheral may withdraw its pin from port use
// - every pin but three has a weak pull-up with its own enable bit
// - pull-up switched off while the pin is an output
// - global pull-up control at option bit 7 disables pull-ups after reset
// - pin three pull-up follows the reset-pin function, no software control
// - data bits 7-6 read zero, bits 5-0 reflect the six pins
// - individual pull-up active only when global control enables pull-ups
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
`define OFS_PIN_LEVELS    12'h000
`define OFS_DIRECTION     12'h004
`define OFS_PULL_UP       12'h008
`define OFS_OPTION        12'h00c
`define OFS_ANALOG_SELECT 12'h010
`define OFS_PERIPH_CLAIM  12'h014
`define OFS_CONFIG        12'h018
`define PIN_THREE         3
`define GLOBAL_PU_BIT     7
`define DIRECTION_RESET   6'h3f
`define PULL_UP_RESET     6'h37
`define OPTION_RESET      8'h80
`define PULL_UP_MASK      6'h37
`define CONFIG_RESET_BIT  0
`endif

// *** logic/gpio_port_pkg.sv ***
package gpio_port_pkg;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  resp_t;
  localparam resp_t RESP_OKAY   = 2'b00;
  localparam resp_t RESP_SLVERR = 2'b10;
endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per pin; stage one feeds only stage two
module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_r;

  // the pins are outside our clock, so metastability must settle first
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stageOne_r <= '0;
      syncOut    <= '0;
    end else if (clkEn) begin
      stageOne_r <= asyncIn;
      syncOut    <= stageOne_r;
    end
  end
endmodule
`default_nettype wire

// *** logic/six_bit_gpio_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_params.svh"
module six_bit_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = 6
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic            clkEn,
  // axi4-lite write address
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // axi4-lite write response
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  // axi4-lite read data
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // pins
  input  wire logic [PINS-1:0] pinIn,
  output logic      [PINS-1:0] pinOut,
  output logic      [PINS-1:0] pinOutEnN,
  output logic      [PINS-1:0] pullUpOn
);
  // register state
  logic [PINS-1:0] outLatch_r;
  logic [PINS-1:0] direction_r;
  logic [PINS-1:0] pullUpEn_r;
  logic [7:0]      option_r;
  logic [PINS-1:0] analogSel_r;
  logic [PINS-1:0] periphClaim_r;
  logic            resetPinFn_r;
  // bus state
  logic            awHeld_r;
  logic [11:0]     awAddr_r;
  logic            wHeld_r;
  logic [31:0]     wData_r;
  logic [3:0]      wStrb_r;
  logic            arBusy_r;
  // synchronised pins and derived views
  logic [PINS-1:0] pinSync;
  wire  [PINS-1:0] dirEff;
  wire  [PINS-1:0] pinRead;
  wire  [PINS-1:0] driveEn;
  wire  [PINS-1:0] puIndividual;
  wire             globalPuOn;

  pin_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  // the global bit is active low: a one after reset turns every pull-up but pin three's off
  assign globalPuOn = ~option_r[`GLOBAL_PU_BIT];

  // per-pin direction, drive and pull-up
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gen_pin
      if (g == `PIN_THREE) begin : gen_in_only
        assign dirEff[g]       = 1'b1;
        assign driveEn[g]      = 1'b0;
        assign pinRead[g]      = resetPinFn_r ? 1'b0 : pinSync[g];
        assign puIndividual[g] = resetPinFn_r;
      end else begin : gen_io
        assign dirEff[g]       = direction_r[g];
        // a claimed pin is released to its peripheral
        assign driveEn[g]      = ~direction_r[g] & ~periphClaim_r[g];
        // analog readback is zero; direction still acts on the pin
        assign pinRead[g]      = analogSel_r[g] ? 1'b0 : pinSync[g];
        assign puIndividual[g] = pullUpEn_r[g] & direction_r[g] & globalPuOn;
      end
    end
  endgenerate

  // outputs to the pad ring
  assign pinOut    = outLatch_r;
  assign pinOutEnN = ~driveEn;
  assign pullUpOn  = puIndividual;

  // write channel decode
  wire        awTake    = s_axi_awvalid & ~awHeld_r;
  wire        wTake     = s_axi_wvalid & ~wHeld_r;
  wire        wrFire    = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire [11:0] wrAddr    = awAddr_r;
  wire [7:0]  wrByte    = wData_r[7:0];
  wire        wrLane0   = wStrb_r[0];
  wire        wrData    = wrFire & wrLane0 & (wrAddr == `OFS_PIN_LEVELS);
  wire        wrDir     = wrFire & wrLane0 & (wrAddr == `OFS_DIRECTION);
  wire        wrPu      = wrFire & wrLane0 & (wrAddr == `OFS_PULL_UP);
  wire        wrOpt     = wrFire & wrLane0 & (wrAddr == `OFS_OPTION);
  wire        wrAna     = wrFire & wrLane0 & (wrAddr == `OFS_ANALOG_SELECT);
  wire        wrClaim   = wrFire & wrLane0 & (wrAddr == `OFS_PERIPH_CLAIM);
  wire        wrCfg     = wrFire & wrLane0 & (wrAddr == `OFS_CONFIG);
  wire        wrMapped  = (wrAddr == `OFS_PIN_LEVELS) | (wrAddr == `OFS_DIRECTION) |
                          (wrAddr == `OFS_PULL_UP) | (wrAddr == `OFS_OPTION) |
                          (wrAddr == `OFS_ANALOG_SELECT) | (wrAddr == `OFS_PERIPH_CLAIM) |
                          (wrAddr == `OFS_CONFIG);

  // read-modify-write form: the sampled pins cancel out, so every latch bit
  // takes the written data bit, whatever level the pin is held at externally
  wire [PINS-1:0] rmwMask  = wrByte[PINS-1:0] ^ pinSync;
  wire [PINS-1:0] latchNxt = pinSync ^ rmwMask;

  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready  = ~wHeld_r;

  // read channel decode
  wire        arTake  = s_axi_arvalid & ~arBusy_r;
  wire [11:0] ra      = s_axi_araddr;
  wire        rdHit   = (ra == `OFS_PIN_LEVELS) | (ra == `OFS_DIRECTION) |
                        (ra == `OFS_PULL_UP) | (ra == `OFS_OPTION) |
                        (ra == `OFS_ANALOG_SELECT) | (ra == `OFS_PERIPH_CLAIM) |
                        (ra == `OFS_CONFIG);
  wire [7:0]  rdPins  = {2'b00, pinRead};
  wire [7:0]  rdDir   = {2'b00, dirEff};
  wire [7:0]  rdPu    = {2'b00, pullUpEn_r & `PULL_UP_MASK};
  wire [7:0]  rdAna   = {2'b00, analogSel_r};
  wire [7:0]  rdClaim = {2'b00, periphClaim_r};
  wire [7:0]  rdCfg   = {7'h00, resetPinFn_r};
  wire [7:0]  rdByte  = (ra == `OFS_PIN_LEVELS)    ? rdPins :
                        (ra == `OFS_DIRECTION)     ? rdDir :
                        (ra == `OFS_PULL_UP)       ? rdPu :
                        (ra == `OFS_OPTION)        ? option_r :
                        (ra == `OFS_ANALOG_SELECT) ? rdAna :
                        (ra == `OFS_PERIPH_CLAIM)  ? rdClaim :
                        (ra == `OFS_CONFIG)        ? rdCfg : 8'h00;

  assign s_axi_arready = ~arBusy_r;

  // write address and data capture, either order
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 12'h000;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else if (clkEn) begin
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // data latch and direction
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      outLatch_r  <= '0;
      direction_r <= `DIRECTION_RESET;
    end else if (clkEn) begin
      if (wrData) outLatch_r <= latchNxt;
      if (wrDir) direction_r <= wrByte[PINS-1:0] | 6'h08;
    end
  end

  // pull-up and option
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pullUpEn_r <= `PULL_UP_RESET;
      option_r   <= `OPTION_RESET;
    end else if (clkEn) begin
      if (wrPu) pullUpEn_r <= wrByte[PINS-1:0] & `PULL_UP_MASK;
      if (wrOpt) option_r <= wrByte;
    end
  end

  // analog select, peripheral claim, reset-pin function
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      analogSel_r   <= '0;
      periphClaim_r <= '0;
      resetPinFn_r  <= 1'b0;
    end else if (clkEn) begin
      if (wrAna) analogSel_r <= wrByte[PINS-1:0] & 6'h37;
      if (wrClaim) periphClaim_r <= wrByte[PINS-1:0] & 6'h37;
      if (wrCfg) resetPinFn_r <= wrByte[`CONFIG_RESET_BIT];
    end
  end

  // read path: one cycle from address to data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arBusy_r     <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (arTake) begin
        arBusy_r     <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        arBusy_r     <= 1'b0;
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/gpio_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_port_sva #(
  parameter int PINS = 6
) (
  // clock and reset
  input wire logic            clock,
  input wire logic            sys_rst,
  // bus
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic [31:0]     s_axi_rdata,
  // pins
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOutEnN,
  input wire logic [PINS-1:0] pullUpOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // pin outputs only move with a completed write
  a_pin3_input: assert property (pinOutEnN[3]) else $error("pin three driven");
  a_pull_output: assert property ((pullUpOn & ~pinOutEnN) == '0)
    else $error("pull-up on a driven pin");
  a_out_on_write: assert property (!$stable({pinOut, pinOutEnN, pullUpOn})
    |-> $rose(s_axi_bvalid)) else $error("pins changed without write");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("upper read bits set");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  // the readies come back with the response, so the answer must clear on its handshake
  a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  cover property (s_axi_bvalid);
  cover property (s_axi_rvalid);
  cover property (|pullUpOn);
endmodule
`default_nettype wire

// *** sim/pin_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  // clock
  input wire logic       clock,
  // device side
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOutEnN,
  input wire logic [5:0] pullUpOn,
  // board drivers
  input wire logic [5:0] extVal,
  input wire logic [5:0] extEn,
  output logic     [5:0] pinIn
);
  logic [5:0] noise_r;
  // an open pin wanders each cycle so nobody can lean on its value
  always_ff @(posedge clock) noise_r <= (noise_r === 6'h15) ? 6'h2a : 6'h15;
  // device driver first, then the board, then the weak pull-up
  assign pinIn = (~pinOutEnN & pinOut) | (pinOutEnN & extEn & extVal)
               | (pinOutEnN & ~extEn & (pullUpOn | noise_r));
endmodule
`default_nettype wire

// *** sim/six_bit_gpio_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module six_bit_gpio_port_tb_top
  import gpio_port_pkg::*;
;
  logic        clock, sys_rst, awV, wV, arV, awR, wR, arR, bV, rV;
  logic [11:0] awA, arA;
  logic [31:0] wD, rD, v;
  resp_t       bR, rR, r;
  logic [5:0]  pOut, pEnN, pPull, pIn, extVal, extEn, de, pl, lvl, known, c3;
  logic [7:0]  ana, dir, pu, opt, cfg, lat, clm;
  logic [5:0]  en;
  int          n_fail = 0, compares = 0, seed = 32'h0512dda1, i;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // bus handshakes are the only way in; clock enable and strobes stay full
  six_bit_gpio_port #(.PINS(6)) dut (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bR),
    .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV),
    .s_axi_rready(1'b1), .pinIn(pIn), .pinOut(pOut), .pinOutEnN(pEnN), .pullUpOn(pPull));
  pin_board board (.clock(clock), .pinOut(pOut), .pinOutEnN(pEnN), .pullUpOn(pPull),
    .extVal(extVal), .extEn(extEn), .pinIn(pIn));
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output resp_t rs);
    int n;
    awA <= a;
    wD <= {24'h0, d};
    awV <= 1'b1;
    wV <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awV && awR) awV <= 1'b0;
      if (wV && wR) wV <= 1'b0;
      if (bV) break;
    end
    rs = bR;
    if (n == 50) n_fail++;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output resp_t rs);
    int n;
    arA <= a;
    arV <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arV && arR) arV <= 1'b0;
      if (rV) break;
    end
    d = rD;
    rs = rR;
    if (n == 50) n_fail++;
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // generous bound on the whole run
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
  initial begin
    {sys_rst, awV, wV, arV, awA, arA, wD, extVal, extEn} <= {1'b1, 71'h0};
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    `chk("enN", 6'h3f, pEnN)
    `chk("pull", 6'h00, pPull)
    for (i = 0; i < 3; i++) begin
      rd(12'h004 + 12'(4 * i), v, r);
      `chk("reset", (i == 0) ? 34'h0fc : (i == 1) ? 34'h0dc : 34'h200, {v, r})
    end
    rd(12'h01c, v, r);
    `chk("rdErr", RESP_SLVERR, r)
    wr(12'h01c, 8'hff, r);
    `chk("wrErr", RESP_SLVERR, r)
    for (i = 0; i < 40; i++) begin
      ana = 8'($random(seed)) & 8'h37;
      dir = 8'($random(seed)) | ana;
      {pu, opt, lat} = 24'($random(seed));
      cfg = 8'($random(seed)) & 8'h01;
      clm = 8'($random(seed)) & 8'h37;
      {extVal, extEn} <= 12'($random(seed));
      wr(12'h010, ana, r);
      wr(12'h004, dir, r);
      wr(12'h008, pu, r);
      wr(12'h00c, opt, r);
      wr(12'h018, cfg, r);
      wr(12'h014, clm, r);
      wr(12'h000, lat, r);
      `chk("resp", RESP_OKAY, r)
      repeat (4) @(posedge clock);
      de = dir[5:0] | 6'h08;
      en = de | clm[5:0];
      c3 = {2'b0, cfg[0], 3'b0};
      pl = (pu[5:0] & 6'h37 & de & {6{~opt[7]}}) | c3;
      `chk("enN", en, pEnN)
      `chk("out", lat[5:0] & ~en, pOut & ~en)
      `chk("pull", pl, pPull)
      lvl = ((~en & lat[5:0]) | (en & extEn & extVal) | (en & ~extEn & pl)) & ~ana[5:0] & ~c3;
      known = ~en | extEn | pl | ana[5:0] | c3;
      rd(12'h000, v, r);
      `chk("pins", {26'h0, lvl & known}, v & {26'h3ffffff, known})
      rd(12'h004, v, r);
      `chk("dirRd", {26'h0, de}, v)
    end
    wrap_up();
  end
endmodule
bind six_bit_gpio_port gpio_port_sva #(.PINS(PINS)) sva (.*);
`default_nettype wire
